// File: design/csc_consts.svh
// Offsets, field positions, reset values and timing counts of the clock source controller.
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH
// Register byte offsets on the Avalon-MM slave.
`define CSC_OFS_CLOCK_CONTROL   4'h0
`define CSC_OFS_CLOCK_SELECT    4'h4
`define CSC_OFS_BACKUP_DOMAIN   4'h8
`define CSC_OFS_CLOCK_INTERRUPT 4'hc
// Clock control register fields.
`define CSC_CC_INT_FAST_EN 0
`define CSC_CC_EXT_FAST_EN 1
`define CSC_CC_EXT_FAST_BYP 2
`define CSC_CC_PLL_EN 3
`define CSC_CC_PLL_SRC 4
`define CSC_CC_MON_EN 5
`define CSC_CC_INT_SLOW_EN 6
// Clock select register fields (low bit of each two-bit field).
`define CSC_CS_SYS_LSB 0
`define CSC_CS_OUT_MUX_LSB 2
`define CSC_CS_RTC_LSB 4
// Backup domain control register fields.
`define CSC_BD_SLOW_EXT_EN 0
`define CSC_BD_SLOW_EXT_BYP 1
`define CSC_BD_DRIVE_LSB 2
// Clock interrupt register fields.
`define CSC_CI_FAST_RDY 0
`define CSC_CI_SLOW_RDY 1
`define CSC_CI_PLL_LOCK 2
`define CSC_CI_SYS_LSB 4
`define CSC_CI_FAIL 8
// Reset values.
`define CSC_RST_INT_FAST_EN 1'b1
`define CSC_RST_INT_SLOW_EN 1'b1
`define CSC_RST_DRIVE 2'h0
// Timing: clock period and the silence that counts as a failed oscillator.
`define CSC_CLK_PERIOD_NS 4
`define CSC_FAIL_TIMEOUT_NS 256
`define CSC_FAIL_CYC ((`CSC_FAIL_TIMEOUT_NS + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS)
// Oscillator edges counted before a ready flag is set.
`define CSC_FAST_START_EDGES 12'h400
`define CSC_SLOW_START_EDGES 12'h040
`endif

// File: design/csc_pkg.sv
// Types of the clock source controller.
package csc_pkg;
  typedef enum logic [2:0] {SW_RUN = 3'b001, SW_DRAIN = 3'b010, SW_GAP = 3'b100} csc_sw_t;
  typedef enum logic [1:0] {SRC_INT_FAST = 2'h0, SRC_EXT_FAST = 2'h1, SRC_PLL = 2'h2,
                            SRC_NONE = 2'h3} csc_src_t;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } csc_bus_req_t;
  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } csc_bus_rsp_t;
  typedef struct packed {
    logic int_fast;
    logic fast_pin;
    logic int_slow;
    logic slow_pin;
    logic pll_clk;
    logic pll_lock;
  } csc_fast_osc_input_pin_t;
  typedef struct packed {
    logic sys_clk;
    logic pll_ref;
    logic out_mux;
    logic wdg;
    logic rtc;
    logic fast_ext;
    logic slow_ext;
  } csc_clk_out_t;
  typedef struct packed {
    logic       fast_xtal_on;
    logic       fast_out_gpio;
    logic       slow_xtal_on;
    logic       slow_out_gpio;
    logic [1:0] slow_drive;
    logic       pll_enable;
    logic       pll_src_ext;
  } csc_pin_ctl_t;
  typedef struct packed {
    logic        wait_r;
    logic [31:0] rdata;
    logic        int_fast_en;
    logic        ext_fast_en;
    logic        ext_fast_byp;
    logic        pll_en;
    logic        pll_src;
    logic        mon_en;
    logic        int_slow_en;
    csc_src_t    sys_req;
    logic [1:0]  out_mux_sel;
    logic [1:0]  rtc_sel;
    logic        slow_ext_en;
    logic        slow_ext_byp;
    logic [1:0]  slow_drv;
    logic        int_prev;
    logic        int_half;
    logic        fast_prev;
    logic [11:0] fast_cnt;
    logic        fast_rdy;
    logic        slow_prev;
    logic [11:0] slow_cnt;
    logic        slow_rdy;
    logic [7:0]  mon_cnt;
    logic        fail;
    logic        brk;
    csc_src_t    sys_cur;
    csc_sw_t     sw_st;
    csc_clk_out_t clk;
    csc_pin_ctl_t pin;
  } csc_state_t;
endpackage

// File: design/csc_top.sv
// Clock source controller: oscillator gating, system clock switch and failure monitor.
// Operation
// RL1 - System clock comes from exactly one of internal fast, external fast or PLL.
// RL2 - Internal fast oscillator feeds system clock directly, halved as PLL reference.
// RL3 - External fast ready flag set when stable; clock withheld until then.
// RL4 - External fast oscillator follows its software enable bit.
// RL5 - Fast bypass plus enable takes an external clock; output pin goes to GPIO.
// RL6 - Slow crystal follows its enable; drive strength changeable at runtime.
// RL7 - Slow ready flag set when stable; slow clock withheld until then.
// RL8 - Slow bypass plus enable takes an external clock; slow output pin freed.
// RL9 - Every clock source can be switched on or off on its own; the internal fast oscillator is held on while it is the system clock.
// RL10 - Internal fast oscillator routable to clock output mux and timer input.
// RL11 - Internal slow oscillator clocks watchdog, optionally RTC, in low power too.
// RL12 - External slow oscillator selectable as RTC clock.
// RL13 - Failure monitor runs only after fast startup, stops when oscillator stops.
// RL14 - On failure disable external fast oscillator and send timer break event.
// RL15 - On failure raise the clock fail interrupt onto the non-maskable vector.
// RL16 - Failure while external fast drives system clock switches to internal fast.
// RL17 - Failure while PLL on external fast is system clock also disables PLL.
// RL18 - Ready flags clear on disable; system clock switches are glitch free.
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "csc_consts.svh"
module csc_top
  import csc_pkg::*;
(
  // Clock and reset.
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Avalon-MM register slave.
  input  wire csc_bus_req_t i_bus,
  output var  csc_bus_rsp_t o_bus,
  // Oscillator and PLL levels, sampled on i_clk.
  input  wire csc_fast_osc_input_pin_t  i_osc,
  // Gated clocks, pin control and events.
  output var  csc_clk_out_t o_clk,
  output var  csc_pin_ctl_t o_pin,
  output logic              o_timer_break,
  output logic              o_clock_fail_interrupt
);

  csc_state_t st_r;
  csc_state_t st_nxt;
  logic       int_edge;
  logic       fast_edge;
  logic       slow_edge;
  logic       mon_active;
  logic       fail_evt;
  logic       cur_lvl;
  logic       req_ok;
  logic       wr_go;
  logic       bus_req;

  // Picks the sampled level of one system clock source.
  function automatic logic src_level(input csc_src_t s, input csc_fast_osc_input_pin_t o);
    case (s)
      SRC_INT_FAST: src_level = o.int_fast;
      SRC_EXT_FAST: src_level = o.fast_pin;
      SRC_PLL:      src_level = o.pll_clk;
      default:      src_level = 1'b0;
    endcase
  endfunction

  // Builds the read word for one register offset; unmapped offsets read zero.
  function automatic logic [31:0] rd_word(input logic [3:0] a, input csc_state_t s,
                                          input logic lock);
    rd_word = 32'h0;
    case (a)
      `CSC_OFS_CLOCK_CONTROL:
      begin
        rd_word[`CSC_CC_INT_FAST_EN]  = s.int_fast_en;
        rd_word[`CSC_CC_EXT_FAST_EN]  = s.ext_fast_en;
        rd_word[`CSC_CC_EXT_FAST_BYP] = s.ext_fast_byp;
        rd_word[`CSC_CC_PLL_EN]       = s.pll_en;
        rd_word[`CSC_CC_PLL_SRC]      = s.pll_src;
        rd_word[`CSC_CC_MON_EN]       = s.mon_en;
        rd_word[`CSC_CC_INT_SLOW_EN]  = s.int_slow_en;
      end
      `CSC_OFS_CLOCK_SELECT:
      begin
        rd_word[`CSC_CS_SYS_LSB +: 2] = s.sys_req;
        rd_word[`CSC_CS_OUT_MUX_LSB +: 2] = s.out_mux_sel;
        rd_word[`CSC_CS_RTC_LSB +: 2] = s.rtc_sel;
      end
      `CSC_OFS_BACKUP_DOMAIN:
      begin
        rd_word[`CSC_BD_SLOW_EXT_EN]    = s.slow_ext_en;
        rd_word[`CSC_BD_SLOW_EXT_BYP]   = s.slow_ext_byp;
        rd_word[`CSC_BD_DRIVE_LSB +: 2] = s.slow_drv;
      end
      `CSC_OFS_CLOCK_INTERRUPT:
      begin
        rd_word[`CSC_CI_FAST_RDY]      = s.fast_rdy;
        rd_word[`CSC_CI_SLOW_RDY]      = s.slow_rdy;
        rd_word[`CSC_CI_PLL_LOCK]      = lock;
        rd_word[`CSC_CI_SYS_LSB +: 2]  = s.sys_cur;
        rd_word[`CSC_CI_FAIL]          = s.fail;
      end
      default: rd_word = 32'h0;
    endcase
  endfunction

  // Edge detection on the sampled oscillator levels and monitor qualifiers.
  assign int_edge   = i_osc.int_fast & ~st_r.int_prev;
  assign fast_edge  = i_osc.fast_pin & ~st_r.fast_prev;
  assign slow_edge  = i_osc.slow_pin & ~st_r.slow_prev;
  assign mon_active = st_r.mon_en & st_r.ext_fast_en & st_r.fast_rdy;  // [RL13]
  assign fail_evt   = mon_active & ~fast_edge & (st_r.mon_cnt == 8'(`CSC_FAIL_CYC - 1));
  assign cur_lvl    = src_level(st_r.sys_cur, i_osc);
  assign bus_req    = i_bus.read | i_bus.write;
  assign wr_go      = i_bus.write & ~st_r.wait_r & i_bus.byteenable[0];

  // A target source may be switched to only once it runs and is stable.
  always_comb
  begin
    case (st_r.sys_req)
      SRC_INT_FAST: req_ok = st_r.int_fast_en;
      SRC_EXT_FAST: req_ok = st_r.fast_rdy;                            // [RL3]
      SRC_PLL:      req_ok = st_r.pll_en & i_osc.pll_lock;
      default:      req_ok = 1'b0;
    endcase
  end

  // Next-state logic for the whole block.
  always_comb
  begin
    st_nxt = st_r;
    // Bus handshake: waitrequest drops for one cycle, one cycle after the request.
    st_nxt.wait_r = bus_req ? ~st_r.wait_r : 1'b1;
    if (bus_req && st_r.wait_r)
      st_nxt.rdata = rd_word(i_bus.address, st_r, i_osc.pll_lock);
    // Software writes to the control bits.
    if (wr_go)
    begin
      case (i_bus.address)
        `CSC_OFS_CLOCK_CONTROL:
        begin
          st_nxt.int_fast_en  = i_bus.writedata[`CSC_CC_INT_FAST_EN];  // [RL9]
          st_nxt.ext_fast_en  = i_bus.writedata[`CSC_CC_EXT_FAST_EN];  // [RL4]
          st_nxt.ext_fast_byp = i_bus.writedata[`CSC_CC_EXT_FAST_BYP]; // [RL5]
          st_nxt.pll_en       = i_bus.writedata[`CSC_CC_PLL_EN];
          st_nxt.pll_src      = i_bus.writedata[`CSC_CC_PLL_SRC];
          st_nxt.mon_en       = i_bus.writedata[`CSC_CC_MON_EN];
          st_nxt.int_slow_en  = i_bus.writedata[`CSC_CC_INT_SLOW_EN];
        end
        `CSC_OFS_CLOCK_SELECT:
        begin
          st_nxt.sys_req = csc_src_t'(i_bus.writedata[`CSC_CS_SYS_LSB +: 2]);
          st_nxt.out_mux_sel = i_bus.writedata[`CSC_CS_OUT_MUX_LSB +: 2];
          st_nxt.rtc_sel = i_bus.writedata[`CSC_CS_RTC_LSB +: 2];
        end
        `CSC_OFS_BACKUP_DOMAIN:
        begin
          st_nxt.slow_ext_en  = i_bus.writedata[`CSC_BD_SLOW_EXT_EN];  // [RL6]
          st_nxt.slow_ext_byp = i_bus.writedata[`CSC_BD_SLOW_EXT_BYP]; // [RL8]
          st_nxt.slow_drv     = i_bus.writedata[`CSC_BD_DRIVE_LSB +: 2];
        end
        `CSC_OFS_CLOCK_INTERRUPT:
          if (i_bus.writedata[`CSC_CI_FAIL])
            st_nxt.fail = 1'b0;
        default: st_nxt.fail = st_r.fail;
      endcase
    end
    // The internal fast oscillator cannot be stopped while it is the system clock source.
    if (st_r.sys_cur == SRC_INT_FAST)
      st_nxt.int_fast_en = 1'b1;
    // Fast external startup: count stable edges, drop ready when disabled.
    st_nxt.fast_prev = i_osc.fast_pin;
    if (!st_r.ext_fast_en)
    begin
      st_nxt.fast_cnt = 12'h0;
      st_nxt.fast_rdy = 1'b0;                                          // [RL18]
    end
    else if (!st_r.fast_rdy && fast_edge)
    begin
      st_nxt.fast_cnt = st_r.fast_cnt + 12'h1;
      st_nxt.fast_rdy = (st_r.fast_cnt == `CSC_FAST_START_EDGES - 12'h1); // [RL3]
    end
    // Slow external startup, same scheme.
    st_nxt.slow_prev = i_osc.slow_pin;
    if (!st_r.slow_ext_en)
    begin
      st_nxt.slow_cnt = 12'h0;
      st_nxt.slow_rdy = 1'b0;                                          // [RL18]
    end
    else if (!st_r.slow_rdy && slow_edge)
    begin
      st_nxt.slow_cnt = st_r.slow_cnt + 12'h1;
      st_nxt.slow_rdy = (st_r.slow_cnt == `CSC_SLOW_START_EDGES - 12'h1); // [RL7]
    end
    // Failure monitor: count cycles since the last fast external edge.
    if (!mon_active || fast_edge)
      st_nxt.mon_cnt = 8'h0;                                           // [RL13]
    else if (!fail_evt)
      st_nxt.mon_cnt = st_r.mon_cnt + 8'h1;
    else
      st_nxt.mon_cnt = 8'h0;
    // Glitch-free switch: finish the old high phase, idle low, start on a low.
    case (st_r.sw_st)
      SW_RUN:
      begin
        st_nxt.clk.sys_clk = cur_lvl;
        if (st_r.sys_req != st_r.sys_cur && req_ok)
          st_nxt.sw_st = SW_DRAIN;                                     // [RL1]
      end
      SW_DRAIN:
      begin
        st_nxt.clk.sys_clk = cur_lvl;
        if (!cur_lvl)
        begin
          st_nxt.sw_st = SW_GAP;                                       // [RL18]
          if (st_r.sys_req != SRC_NONE)
            st_nxt.sys_cur = st_r.sys_req;
        end
      end
      SW_GAP:
      begin
        st_nxt.clk.sys_clk = 1'b0;
        if (!cur_lvl)
          st_nxt.sw_st = SW_RUN;
      end
      default:
      begin
        st_nxt.clk.sys_clk = 1'b0;
        st_nxt.sw_st       = SW_GAP;
      end
    endcase
    // Failover on a detected external fast failure; wins over any software write.
    st_nxt.brk = fail_evt;                                             // [RL14]
    if (fail_evt)
    begin
      st_nxt.fail        = 1'b1;                                       // [RL15]
      st_nxt.ext_fast_en = 1'b0;                                       // [RL14]
      if (st_r.sys_cur == SRC_EXT_FAST || (st_r.sys_cur == SRC_PLL && st_r.pll_src))
      begin
        st_nxt.sys_cur     = SRC_INT_FAST;                             // [RL16]
        st_nxt.sys_req     = SRC_INT_FAST;
        st_nxt.int_fast_en = 1'b1;
        st_nxt.sw_st       = SW_GAP;
        st_nxt.clk.sys_clk = 1'b0;
        if (st_r.sys_cur == SRC_PLL)
          st_nxt.pll_en = 1'b0;                                        // [RL17]
      end
    end
    // Internal fast oscillator halved for the PLL reference.
    st_nxt.int_prev = i_osc.int_fast;
    if (int_edge)
      st_nxt.int_half = ~st_r.int_half;                                // [RL2]
    st_nxt.clk.pll_ref = st_r.pll_src ? (st_r.fast_rdy & i_osc.fast_pin)
                                      : (st_r.int_fast_en & st_r.int_half);
    // Gated oscillator clocks for their consumers.
    st_nxt.clk.fast_ext = st_r.fast_rdy & i_osc.fast_pin;              // [RL3]
    st_nxt.clk.slow_ext = st_r.slow_rdy & i_osc.slow_pin;              // [RL7]
    st_nxt.clk.wdg      = st_r.int_slow_en & i_osc.int_slow;           // [RL11]
    case (st_r.rtc_sel)
      2'h1:    st_nxt.clk.rtc = st_r.slow_rdy & i_osc.slow_pin;        // [RL12]
      2'h2:    st_nxt.clk.rtc = st_r.int_slow_en & i_osc.int_slow;     // [RL11]
      default: st_nxt.clk.rtc = 1'b0;
    endcase
    // Clock output mux, which also feeds the calibration timer input.
    case (st_r.out_mux_sel)
      2'h1:    st_nxt.clk.out_mux = st_r.int_fast_en & i_osc.int_fast; // [RL10]
      2'h2:    st_nxt.clk.out_mux = st_r.clk.sys_clk;
      2'h3:    st_nxt.clk.out_mux = st_r.fast_rdy & i_osc.fast_pin;
      default: st_nxt.clk.out_mux = 1'b0;
    endcase
    // Pin and PLL control taken from the next control bits.
    st_nxt.pin.fast_xtal_on  = st_nxt.ext_fast_en & ~st_nxt.ext_fast_byp;  // [RL5]
    st_nxt.pin.fast_out_gpio = st_nxt.ext_fast_en & st_nxt.ext_fast_byp;   // [RL5]
    st_nxt.pin.slow_xtal_on  = st_nxt.slow_ext_en & ~st_nxt.slow_ext_byp;  // [RL8]
    st_nxt.pin.slow_out_gpio = st_nxt.slow_ext_en & st_nxt.slow_ext_byp;   // [RL8]
    st_nxt.pin.slow_drive    = st_nxt.slow_drv;                            // [RL6]
    st_nxt.pin.pll_enable    = st_nxt.pll_en;                              // [RL9]
    st_nxt.pin.pll_src_ext   = st_nxt.pll_src;
  end

  // State register with asynchronous reset.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r             <= '0;
      st_r.wait_r      <= 1'b1;
      st_r.int_fast_en <= `CSC_RST_INT_FAST_EN;
      st_r.int_slow_en <= `CSC_RST_INT_SLOW_EN;
      st_r.slow_drv    <= `CSC_RST_DRIVE;
      st_r.sys_req     <= SRC_INT_FAST;
      st_r.sys_cur     <= SRC_INT_FAST;
      st_r.sw_st       <= SW_GAP;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from the state register.
  assign o_bus.waitrequest     = st_r.wait_r;
  assign o_bus.readdata        = st_r.rdata;
  assign o_clk                 = st_r.clk;
  assign o_pin                 = st_r.pin;
  assign o_timer_break         = st_r.brk;
  assign o_clock_fail_interrupt = st_r.fail;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_one_source;
    st_r.sys_cur != SRC_NONE;
  endproperty
  a_one_source: assert property (p_one_source) // [RL1]
    else $error("System clock source is not one of the three sources.");
  property p_fast_gated;
    o_clk.fast_ext |-> $past(st_r.fast_rdy);
  endproperty
  a_fast_gated: assert property (p_fast_gated) // [RL3]
    else $error("Fast external clock released before ready.");
  property p_slow_gated;
    o_clk.slow_ext |-> $past(st_r.slow_rdy);
  endproperty
  a_slow_gated: assert property (p_slow_gated) // [RL7]
    else $error("Slow external clock released before ready.");
  property p_rdy_clear;
    !st_r.ext_fast_en ##1 !st_r.ext_fast_en |-> !st_r.fast_rdy ##1 !o_clk.fast_ext;
  endproperty
  a_rdy_clear: assert property (p_rdy_clear) // [RL18]
    else $error("Fast ready flag held while oscillator disabled.");
  property p_bypass_pin;
    st_r.ext_fast_en && st_r.ext_fast_byp |-> o_pin.fast_out_gpio && !o_pin.fast_xtal_on;
  endproperty
  a_bypass_pin: assert property (p_bypass_pin) // [RL5]
    else $error("Fast output pin not freed in bypass.");
  property p_mon_idle;
    !mon_active |=> st_r.mon_cnt == 8'h0 && !st_r.brk;
  endproperty
  a_mon_idle: assert property (p_mon_idle) // [RL13]
    else $error("Failure monitor ran while inactive.");
  property p_fail_event;
    $rose(st_r.fail) && st_r.brk |-> !st_r.ext_fast_en ##1 !st_r.brk;
  endproperty
  a_fail_event: assert property (p_fail_event) // [RL14]
    else $error("Failure did not disable oscillator or break pulse too long.");
  property p_fail_irq;
    fail_evt |=> o_clock_fail_interrupt && o_timer_break;
  endproperty
  a_fail_irq: assert property (p_fail_irq) // [RL15]
    else $error("Failure did not raise interrupt and break.");
  property p_failover;
    fail_evt && st_r.sys_cur == SRC_EXT_FAST |=> st_r.sys_cur == SRC_INT_FAST && !o_clk.sys_clk;
  endproperty
  a_failover: assert property (p_failover) // [RL16]
    else $error("Failure did not move system clock to internal fast.");
  property p_pll_off;
    fail_evt && st_r.sys_cur == SRC_PLL && st_r.pll_src |=> !st_r.pll_en ##1 !o_pin.pll_enable;
  endproperty
  a_pll_off: assert property (p_pll_off) // [RL17]
    else $error("PLL on failed source left enabled.");
  property p_gap_low;
    st_r.sw_st == SW_GAP |=> !o_clk.sys_clk;
  endproperty
  a_gap_low: assert property (p_gap_low) // [RL18]
    else $error("System clock not held low during switch gap.");
  c_switch_pll: cover property (st_r.sw_st == SW_GAP && st_r.sys_cur == SRC_PLL);
  c_fast_ready: cover property ($rose(st_r.fast_rdy));
  c_failover:   cover property (fail_evt && st_r.sys_cur != SRC_INT_FAST);
  c_bus_read:   cover property (i_bus.read && !o_bus.waitrequest);

endmodule
`default_nettype wire

// File: bench/csc_osc_model.sv
// Behavioural oscillators, crystals, bypass sources and PLL facing the clock controller.
`timescale 1ns/10ps
`default_nettype none
module csc_osc_model
  import csc_pkg::*;
(
  // Clock and reset.
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Pin control from the controller and a fault switch from the bench.
  input  wire csc_pin_ctl_t i_pin,
  input  wire logic         i_stop_fast,
  // Oscillator levels.
  output var  csc_fast_osc_input_pin_t  o_osc
);
  logic [3:0] div_r;
  logic [3:0] lock_r;

  // One divider sets every rate below half the system clock; the PLL locks after a delay.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_r  <= 4'h0;
      lock_r <= 4'h0;
    end
    else
    begin
      div_r  <= div_r + 4'h1;
      lock_r <= i_pin.pll_enable ? lock_r + {3'h0, ~&lock_r} : 4'h0;
    end
  end

  // An unpowered or failed external source or PLL sits flat, so a dead crystal shows no edges; the internal oscillators always run.
  always_comb
  begin
    o_osc.int_fast = div_r[1];
    o_osc.fast_pin = div_r[1] & ~i_stop_fast & (i_pin.fast_xtal_on | i_pin.fast_out_gpio);
    o_osc.int_slow = div_r[3];
    o_osc.slow_pin = div_r[2] & (i_pin.slow_xtal_on | i_pin.slow_out_gpio);
    o_osc.pll_clk  = div_r[1] & i_pin.pll_enable;
    o_osc.pll_lock = &lock_r;
  end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the clock source controller.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import csc_pkg::*;
;
  logic         i_clk;
  logic         i_rst_n;
  logic         stop_fast;
  logic         brk;
  logic         intr;
  logic [31:0]  rd;
  int           err_count;
  int           checks;
  csc_bus_req_t bus;
  csc_bus_rsp_t o_bus;
  csc_bus_rsp_t bsmp;
  csc_fast_osc_input_pin_t  osc;
  csc_clk_out_t o_clk;
  csc_pin_ctl_t o_pin;
  csc_pin_ctl_t psmp;

  // Design and its oscillators.
  csc_top csc_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_bus(o_bus),
    .i_osc(osc), .o_clk(o_clk), .o_pin(o_pin), .o_timer_break(brk),
    .o_clock_fail_interrupt(intr));
  csc_osc_model csc_osc_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pin(o_pin),
    .i_stop_fast(stop_fast), .o_osc(osc));

  // Clock, and settled copies of outputs taken midway between edges.
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(negedge i_clk)
  begin
    bsmp = o_bus;
    psmp = o_pin;
  end

  // Compares one value and counts it.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low at an edge.
  task xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    bus.read      <= ~wr;
    bus.write     <= wr;
    bus.address   <= a;
    bus.writedata <= wd;
    // Only the watchdog ends a wait that never sees waitrequest low.
    do
      @(posedge i_clk);
    while (bsmp.waitrequest !== 1'b0);
    rd = bsmp.readdata;
    bus.read  <= 1'b0;
    bus.write <= 1'b0;
    @(posedge i_clk);
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rdc(input logic [3:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Reads until the masked field matches, within a bounded count.
  task poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, a, 32'h0);
      n++;
    end
    while ((rd & m) !== exp && n < 4000);
    chk(rd & m, exp);
  endtask

  task pinc(input logic [7:0] exp);
    repeat (3) @(posedge i_clk);
    chk({24'h0, psmp}, {24'h0, exp});
  endtask

  // Tells whether one gated clock output toggles over a window.
  task tog(input int idx, input logic exp);
    logic s0, s1;
    s0 = 1'b0;
    s1 = 1'b0;
    repeat (32)
    begin
      @(negedge i_clk);
      if (o_clk[idx] === 1'b1) s1 = 1'b1;
      else s0 = 1'b1;
    end
    @(posedge i_clk);
    chk({31'h0, s0 & s1}, {31'h0, exp});
  endtask

  // Looks for a break pulse over a window longer than the failure timeout.
  task brkw(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (150)
    begin
      @(negedge i_clk);
      if (brk === 1'b1) seen = 1'b1;
    end
    @(posedge i_clk);
    chk({31'h0, seen}, {31'h0, exp});
  endtask

  task end_sim;
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Cuts a hang short.
  initial
  begin
    #200000;
    err_count++;
    end_sim;
  end

  // Test sequence.
  initial
  begin
    err_count = 0;
    checks    = 0;
    i_rst_n   = 1'b0;
    stop_fast = 1'b0;
    bus       = '0;
    bus.byteenable = 4'hf;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rdc(4'h0, 32'h41);
    rdc(4'h4, 32'h0);
    rdc(4'h8, 32'h0);
    rdc(4'hc, 32'h0);
    wr(4'h2, 32'hff);
    rdc(4'h2, 32'h0);
    pinc(8'h00);
    tog(6, 1'b1);
    tog(5, 1'b1);
    tog(3, 1'b1);
    wr(4'h4, 32'h28);
    tog(2, 1'b1);
    tog(4, 1'b1);
    $display("reset test done");
    wr(4'h0, 32'h61);
    brkw(1'b0);
    wr(4'h0, 32'h47);
    pinc(8'h40);
    wr(4'h0, 32'h63);
    pinc(8'h80);
    tog(1, 1'b0);
    poll(4'hc, 32'h1, 32'h1);
    tog(1, 1'b1);
    wr(4'h4, 32'h5);
    poll(4'hc, 32'h30, 32'h10);
    tog(4, 1'b1);
    $display("fast source test done");
    stop_fast <= 1'b1;
    brkw(1'b1);
    chk({31'h0, intr}, 32'h1);
    rdc(4'h0, 32'h61);
    rdc(4'hc, 32'h100);
    tog(6, 1'b1);
    wr(4'hc, 32'h100);
    rdc(4'hc, 32'h0);
    $display("failover test done");
    stop_fast <= 1'b0;
    wr(4'h4, 32'h2);
    wr(4'h0, 32'h7b);
    poll(4'hc, 32'h31, 32'h21);
    pinc(8'h83);
    stop_fast <= 1'b1;
    brkw(1'b1);
    rdc(4'h0, 32'h71);
    pinc(8'h01);
    $display("pll failover test done");
    wr(4'h8, 32'hd);
    pinc(8'h2d);
    wr(4'h4, 32'h10);
    tog(2, 1'b0);
    poll(4'hc, 32'h2, 32'h2);
    tog(2, 1'b1);
    wr(4'h8, 32'h3);
    pinc(8'h11);
    wr(4'h0, 32'h31);
    tog(3, 1'b0);
    wr(4'h8, 32'h0);
    rdc(4'hc, 32'h100);
    $display("slow source test done");
    end_sim;
  end
endmodule
`default_nettype wire
